// [rtl/mlsc_pkg.sv]
// Shared constants and types for the multi-lane serial configuration output stage
package mlsc_pkg;

  // ----------------------------------------------------------------
  // Lane geometry and modes
  // ----------------------------------------------------------------
  localparam int        LANE_COUNT   = 8;
  localparam int        WORD_WIDTH   = 8;
  localparam int        FIFO_DEPTH   = 16;
  localparam logic [3:0] MODE_ONE    = 4'h1;
  localparam logic [3:0] MODE_TWO    = 4'h2;
  localparam logic [3:0] MODE_FOUR   = 4'h4;
  localparam logic [3:0] MODE_EIGHT  = 4'h8;
  localparam logic [3:0] BITS_PER_WORD = 4'h8;

  // ----------------------------------------------------------------
  // Clock source and timing
  // ----------------------------------------------------------------
  localparam logic      CLK_SRC_INTERNAL  = 1'b0;
  localparam logic      CLK_SRC_EXTERNAL  = 1'b1;
  localparam int        CORE_PERIOD_NS    = 10;
  localparam int        OSC_HALF_PERIOD_NS = 50;
  localparam int        OSC_HALF_CYCLES_INT =
    (OSC_HALF_PERIOD_NS / CORE_PERIOD_NS) < 1 ? 1 : (OSC_HALF_PERIOD_NS / CORE_PERIOD_NS);
  localparam logic [7:0] OSC_HALF_CYCLES  = 8'(OSC_HALF_CYCLES_INT);

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LANES_RESET      = 8'h00;
  localparam logic [3:0] MODE_RESET       = 4'h1;
  localparam logic [3:0] COUNT_RESET      = 4'h0;

  // ----------------------------------------------------------------
  // Shared flash port
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [20:0] addr;
    logic [15:0] dq;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
  } mlsc_flash_port_t;

  localparam mlsc_flash_port_t FLASH_IDLE = '{addr: 21'h00000, dq: 16'h0000,
                                              ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};

  typedef enum logic [1:0] {
    MLSC_IDLE,
    MLSC_RUN,
    MLSC_DONE
  } mlsc_state_t;

endpackage

// [rtl/mlsc_top.sv]
// Multi-lane serial configuration output stage with its staging FIFO

// ------------------------------------------------------------------
// Staging FIFO
// ------------------------------------------------------------------
module mlsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             wr_valid_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  wr_ready_out,
  output logic                  rd_valid_out,
  output logic      [WIDTH-1:0] rd_data_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              empty = (wr_ptr == rd_ptr);
  wire              full  = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  wire              do_wr = wr_valid_in && !full;
  wire              do_rd = rd_ready_in && !empty;

  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge core_clk_in) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

module mlsc_top
  import mlsc_pkg::*;
(
  input  wire logic                  core_clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic                  run_start_in,
  input  wire logic [3:0]            lane_mode_setting_in,
  input  wire logic                  clock_source_setting_in,
  input  wire logic                  external_clock_input_in,
  input  wire logic                  fill_valid_in,
  input  wire logic [WORD_WIDTH-1:0] fill_data_in,
  output logic                       fill_ready_out,
  input  wire logic                  fill_last_in,
  input  wire mlsc_flash_port_t      ctrl_flash_in,
  output mlsc_flash_port_t           flash_pins_out,
  output logic                       flash_pins_oe_out,
  output logic                       config_clock_out,
  output logic [LANE_COUNT-1:0]      config_lanes_out,
  output logic                       config_lanes_oe_out,
  output logic                       config_done_out,
  output logic                       run_busy_out
);

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  mlsc_state_t      state;
  logic [3:0]       run_mode;
  logic             run_clk_src;
  logic             last_seen;
  logic [WORD_WIDTH-1:0] shreg;
  logic [3:0]       sh_count;
  logic             lane_valid;
  wire              running = (state == MLSC_RUN);

  // Undefined codes fall back to one lane rather than stalling the run
  wire              mode_ok = (lane_mode_setting_in == MODE_ONE) ||
                              (lane_mode_setting_in == MODE_TWO) ||
                              (lane_mode_setting_in == MODE_FOUR) ||
                              (lane_mode_setting_in == MODE_EIGHT);
  wire [3:0]        start_mode = mode_ok ? lane_mode_setting_in : MODE_ONE;

  // ----------------------------------------------------------------
  // Clock source: divider or synchronised external input
  // ----------------------------------------------------------------
  logic [7:0]       osc_count;
  logic             osc_phase;
  logic             ext_meta;
  logic             ext_sync;
  logic             ext_prev;
  wire              osc_wrap  = (osc_count == OSC_HALF_CYCLES - 8'h01);
  wire              osc_rise  = osc_wrap && !osc_phase;
  wire              osc_fall  = osc_wrap && osc_phase;
  wire              ext_rise  = ext_sync && !ext_prev;
  wire              ext_fall  = !ext_sync && ext_prev;
  wire              use_ext   = (run_clk_src == CLK_SRC_EXTERNAL);
  wire              tick_rise = use_ext ? ext_rise : osc_rise;
  wire              tick_fall = use_ext ? ext_fall : osc_fall;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      osc_count <= 8'h00;
      osc_phase <= 1'b0;
    end else begin
      osc_count <= osc_wrap ? 8'h00 : osc_count + 8'h01;
      if (osc_wrap) begin
        osc_phase <= !osc_phase;
      end
    end
  end

  // External clock is input only; two flops before any edge logic
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= external_clock_input_in;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // ----------------------------------------------------------------
  // Staging FIFO
  // ----------------------------------------------------------------
  wire                  fifo_valid;
  wire [WORD_WIDTH-1:0] fifo_data;
  wire                  fifo_take = running && (sh_count == COUNT_RESET) && fifo_valid;

  mlsc_fifo #(
    .WIDTH (WORD_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in  (core_clk_in),
    .reset_n_in   (reset_n_in),
    .wr_valid_in  (fill_valid_in && running),
    .wr_data_in   (fill_data_in),
    .wr_ready_out (fill_ready_out),
    .rd_valid_out (fifo_valid),
    .rd_data_out  (fifo_data),
    .rd_ready_in  (fifo_take)
  );

  // ----------------------------------------------------------------
  // Lane serializer
  // ----------------------------------------------------------------
  // Data changes only while the clock is low so targets see stable bits
  wire              present  = running && !config_clock_out && !lane_valid &&
                               (sh_count != COUNT_RESET);
  wire [7:0]        lane_mask = 8'((9'h001 << run_mode) - 9'h001);
  wire [7:0]        next_lanes = shreg & lane_mask;
  wire [7:0]        next_shreg = 8'(shreg >> run_mode);
  wire              drained  = last_seen && !fifo_valid && (sh_count == COUNT_RESET) &&
                               !lane_valid && !config_clock_out;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shreg            <= LANES_RESET;
      sh_count         <= COUNT_RESET;
      lane_valid       <= 1'b0;
      config_lanes_out <= LANES_RESET;
      config_clock_out <= 1'b0;
    end else if (!running) begin
      // Park lanes low so a narrower next run shows no stale upper bits
      config_lanes_out <= LANES_RESET;
      sh_count         <= COUNT_RESET;
      lane_valid       <= 1'b0;
      config_clock_out <= 1'b0;
    end else begin
      if (fifo_take) begin
        shreg    <= fifo_data;
        sh_count <= BITS_PER_WORD;
      end else if (present) begin
        config_lanes_out <= next_lanes;
        shreg            <= next_shreg;
        sh_count         <= sh_count - run_mode;
        lane_valid       <= 1'b1;
      end
      if (tick_rise && lane_valid && !config_clock_out) begin
        config_clock_out <= 1'b1;
      end else if (tick_fall && config_clock_out) begin
        config_clock_out <= 1'b0;
        lane_valid       <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Run state, settings capture and flash ownership
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state       <= MLSC_IDLE;
      run_mode    <= MODE_RESET;
      run_clk_src <= CLK_SRC_INTERNAL;
      last_seen   <= 1'b0;
    end else begin
      case (state)
        MLSC_IDLE, MLSC_DONE: begin
          if (run_start_in) begin
            state       <= MLSC_RUN;
            run_mode    <= start_mode;
            run_clk_src <= clock_source_setting_in;
            last_seen   <= 1'b0;
          end
        end
        MLSC_RUN: begin
          if (fill_valid_in && fill_ready_out && fill_last_in) begin
            last_seen <= 1'b1;
          end
          if (drained) begin
            state <= MLSC_DONE;
          end
        end
        default: begin
          state <= MLSC_IDLE;
        end
      endcase
    end
  end

  // Registered pins; released the cycle after the run leaves RUN
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flash_pins_out    <= FLASH_IDLE;
      flash_pins_oe_out <= 1'b0;
    end else begin
      flash_pins_out    <= running ? ctrl_flash_in : FLASH_IDLE;
      flash_pins_oe_out <= running;
    end
  end

  // All eight lanes are driven in every mode, unused ones held low
  assign config_lanes_oe_out = 1'b1;
  assign config_done_out     = (state == MLSC_DONE);
  assign run_busy_out        = running;

endmodule

// [tb/mlsc_properties.sv]
// Checker for the multi-lane configuration output stage
module mlsc_checker
  import mlsc_pkg::*;
(
  input wire logic                  core_clk_in,
  input wire logic                  reset_n_in,
  input wire logic                  run_start_in,
  input wire logic [3:0]            lane_mode_setting_in,
  input wire logic                  clock_source_setting_in,
  input wire mlsc_flash_port_t      flash_pins_out,
  input wire logic                  flash_pins_oe_out,
  input wire logic                  config_clock_out,
  input wire logic [LANE_COUNT-1:0] config_lanes_out,
  input wire logic                  config_lanes_oe_out,
  input wire logic                  config_done_out,
  input wire logic                  run_busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lane_mask;
  logic       src_ext;
  wire        start_taken = run_start_in && !run_busy_out;
  wire  [7:0] next_lane_mask = (lane_mode_setting_in == MODE_TWO)   ? 8'h03 :
                               (lane_mode_setting_in == MODE_FOUR)  ? 8'h0F :
                               (lane_mode_setting_in == MODE_EIGHT) ? 8'hFF : 8'h01;
  // Settings captured once, so mid-run changes must not show
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lane_mask <= 8'h01;
      src_ext   <= 1'b0;
    end else if (start_taken) begin
      lane_mask <= next_lane_mask;
      src_ext   <= clock_source_setting_in;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_grab;
    run_busy_out ##1 flash_pins_oe_out;
  endsequence
  sequence s_high_five;
    config_clock_out [*5] ##1 !config_clock_out;
  endsequence
  AST_START_GRAB: assert property (start_taken |=> s_grab)
    else $error("start did not seize the flash port");
  AST_FLASH_FREE: assert property ($fell(run_busy_out) |=> !flash_pins_oe_out)
    else $error("flash port not released after run");
  AST_IDLE_PINS: assert property (!run_busy_out && !flash_pins_oe_out |-> flash_pins_out == FLASH_IDLE)
    else $error("flash pins not idle while released");
  AST_LANES_DRIVEN: assert property (config_lanes_oe_out)
    else $error("lanes floated");
  AST_UNUSED_ZERO: assert property (run_busy_out |-> (config_lanes_out & ~lane_mask) == 8'h00)
    else $error("unused lane carries data");
  AST_LANES_STEADY: assert property (config_clock_out |-> $stable(config_lanes_out))
    else $error("lanes moved while clock high");
  AST_OSC_HALF: assert property ($rose(config_clock_out) && !src_ext |-> s_high_five)
    else $error("internal clock high phase wrong");
  AST_RUN_END: assert property ($fell(run_busy_out) |-> config_done_out && !config_clock_out)
    else $error("run ended without done");
endmodule

bind mlsc_top mlsc_checker u_chk (.core_clk_in, .reset_n_in, .run_start_in, .lane_mode_setting_in,
  .clock_source_setting_in, .flash_pins_out, .flash_pins_oe_out, .config_clock_out,
  .config_lanes_out, .config_lanes_oe_out, .config_done_out, .run_busy_out);

// [tb/mlsc_target_model.sv]
// Passive target devices shifting in lane data on the configuration clock
module mlsc_target_model (
  input wire logic       config_clock_in,
  input wire logic [7:0] config_lanes_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  lane_bits [8];
  int unsigned clocks_seen = 0;
  task automatic clear();
    clocks_seen = 0;
  endtask
  // Every target samples its own lane on the same rising edge
  always @(posedge config_clock_in) begin
    for (int i = 0; i < 8; i++) begin
      lane_bits[i] <= {config_lanes_in[i], lane_bits[i][7:1]};
    end
    clocks_seen <= clocks_seen + 1;
  end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the multi-lane configuration output stage
module tb_top
  import mlsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             core_clk = 1'b0;
  logic             reset_n = 1'b0;
  logic             run_start = 1'b0;
  logic [3:0]       lane_mode = MODE_ONE;
  logic             clk_src = CLK_SRC_INTERNAL;
  logic             ext_clk = 1'b0;
  logic             fill_valid = 1'b0;
  logic             fill_last = 1'b0;
  logic [7:0]       fill_data = 8'h00;
  mlsc_flash_port_t ctrl_flash = '{21'h0A5A5, 16'h3C3C, 1'b0, 1'b0, 1'b1};
  mlsc_flash_port_t flash_pins;
  logic             flash_oe, cfg_clk, lanes_oe, done, busy, fill_ready;
  logic [7:0]       lanes;
  int               errors = 0;
  int               check_count = 0;
  always #5 core_clk = ~core_clk;
  always #62.5 ext_clk = ~ext_clk;
  mlsc_top dut (.core_clk_in(core_clk), .reset_n_in(reset_n), .run_start_in(run_start),
    .lane_mode_setting_in(lane_mode), .clock_source_setting_in(clk_src),
    .external_clock_input_in(ext_clk), .fill_valid_in(fill_valid), .fill_data_in(fill_data),
    .fill_ready_out(fill_ready), .fill_last_in(fill_last), .ctrl_flash_in(ctrl_flash),
    .flash_pins_out(flash_pins), .flash_pins_oe_out(flash_oe), .config_clock_out(cfg_clk),
    .config_lanes_out(lanes), .config_lanes_oe_out(lanes_oe), .config_done_out(done),
    .run_busy_out(busy));
  mlsc_target_model tgt (.config_clock_in(cfg_clk), .config_lanes_in(lanes));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask
  function automatic logic [7:0] wd(input int k);
    return 8'hA5 ^ 8'(k * 29);
  endfunction
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One run: start, stream n words, wait for done, compare what targets saw
  task automatic run_words(input logic [3:0] m, input logic s, input int n, output logic full);
    int         w;
    int         nl;
    int         t;
    int         c;
    logic       r;
    logic [7:0] e;
    logic [7:0] v;
    nl = (m == MODE_TWO || m == MODE_FOUR || m == MODE_EIGHT) ? int'(m) : 1;
    full = 1'b0;
    tgt.clear();
    @(posedge core_clk);
    run_start <= 1'b1;
    lane_mode <= m;
    clk_src <= s;
    @(posedge core_clk);
    run_start <= 1'b0;
    lane_mode <= (m == MODE_TWO) ? MODE_EIGHT : MODE_TWO;
    @(posedge core_clk);
    @(negedge core_clk);
    check("flash oe", 1, flash_oe);
    check("flash pins", ctrl_flash, flash_pins);
    check("lanes oe", 1, lanes_oe);
    // Start words on a rising edge so the first one is not taken twice
    @(posedge core_clk);
    for (int k = 0; k < n; k++) begin
      fill_valid <= 1'b1;
      fill_data <= wd(k);
      fill_last <= (k == n - 1);
      do begin
        @(negedge core_clk);
        r = fill_ready;
        if (!r) full = 1'b1;
        @(posedge core_clk);
      end while (!r);
    end
    fill_valid <= 1'b0;
    fill_last <= 1'b0;
    w = 0;
    while (done !== 1'b1 && w < 20000) begin
      @(negedge core_clk);
      w++;
    end
    check("done", 1, done);
    t = n * 8 / nl;
    check("clocks", t, tgt.clocks_seen);
    for (int l = 0; l < 8; l++) begin
      for (int j = 0; j < 8; j++) begin
        c = t - 8 + j;
        v = wd(c * nl / 8);
        e[j] = (l < nl) ? v[(c * nl) % 8 + l] : 1'b0;
      end
      check("lane bits", e, tgt.lane_bits[l]);
    end
    repeat (2) @(negedge core_clk);
    check("flash oe idle", 0, flash_oe);
    check("flash pins idle", FLASH_IDLE, flash_pins);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_modes();
    logic [3:0] modes [5] = '{MODE_ONE, MODE_TWO, MODE_FOUR, MODE_EIGHT, 4'h3};
    logic       f;
    for (int i = 0; i < 5; i++) begin
      run_words(modes[i], CLK_SRC_INTERNAL, (i < 4) ? int'(modes[i]) : 1, f);
    end
  endtask
  task automatic test_external();
    logic f;
    run_words(MODE_FOUR, CLK_SRC_EXTERNAL, 8, f);
  endtask
  // Slow single lane drains far slower than words arrive
  task automatic test_fifo_full();
    logic f;
    run_words(MODE_ONE, CLK_SRC_INTERNAL, 20, f);
    check("fifo refused", 1, f);
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    test_modes();
    test_external();
    test_fifo_full();
    wrap_up();
  end
  initial begin
    #200000;
    errors++;
    wrap_up();
  end
endmodule
